/* core/gvp_pkg.sv */
// Constants, field layouts and carriers for the GPIO and video path config slice.
// Assumes one register clock, a plain strobe register port and an 8-bit data path.
package gvp_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int GVP_ADDR_W = 8;
  localparam int GVP_DATA_W = 8;
  localparam int GVP_FC_W = 7;
  localparam int GVP_NUM_PINS = 4;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] GVP_OFS_PINS_5_6 = 8'h20;
  localparam logic [7:0] GVP_OFS_PINS_7_8 = 8'h21;
  localparam logic [7:0] GVP_OFS_VIDEO_PATH = 8'h22;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] GVP_RST_PINS_5_6 = 8'h00;
  localparam logic [7:0] GVP_RST_PINS_7_8 = 8'h00;
  localparam logic [7:0] GVP_RST_VIDEO_PATH = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int GVP_LO_PIN_LSB = 0;
  localparam int GVP_HI_PIN_LSB = 4;
  localparam int GVP_BIT_HOLD = 7;
  localparam int GVP_FC_MSB = 6;

  // Pin codes, written {direction, function_enable}
  localparam logic [1:0] GVP_CODE_FUNC_OUT = 2'h0;
  localparam logic [1:0] GVP_CODE_GP_OUT = 2'h1;
  localparam logic [1:0] GVP_CODE_TRISTATE = 2'h2;
  localparam logic [1:0] GVP_CODE_GP_IN = 2'h3;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // One pin nibble, bit 3 down to bit 0
  typedef struct packed {
    logic out_level;
    logic remote_ctrl;
    logic direction;
    logic function_enable;
  } gvp_pin_cfg_t;

  // Video path control, bit 7 down to bit 0
  typedef struct packed {
    logic hold_local_settings;
    logic pass_video_unqualified;
    logic video_valid_polarity;
    logic suppress_audio_on_video_pins;
    logic four_chan_from_reg;
    logic video_18bit;
    logic audio_inband;
    logic four_chan_enable;
  } gvp_vpath_t;

endpackage

/* core/gvp_pin_ctrl.sv */
// One general-purpose pin: input synchroniser and registered pad drive.
// Assumes the remote level and functional data arrive on the register clock.
module gvp_pin_ctrl
  import gvp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Configuration and sources
  input wire gvp_pin_cfg_t i_cfg,
  input wire logic i_func_out,
  input wire logic i_remote_level,
  // Pad
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_in_level
);

  logic sync_meta;
  logic next_pad_out;
  logic next_pad_oe;

  // Pad drive selection from the pin code and remote control
  always_comb begin
    next_pad_out = 1'b0;
    next_pad_oe = 1'b0;
    if (i_cfg.remote_ctrl) begin
      next_pad_oe = 1'b1;
      next_pad_out = i_remote_level;
    end else begin
      unique case ({i_cfg.direction, i_cfg.function_enable})
        GVP_CODE_FUNC_OUT: begin
          next_pad_oe = 1'b1;
          next_pad_out = i_func_out;
        end
        GVP_CODE_GP_OUT: begin
          next_pad_oe = 1'b1;
          next_pad_out = i_cfg.out_level;
        end
        GVP_CODE_TRISTATE: begin
          next_pad_oe = 1'b0;
        end
        GVP_CODE_GP_IN: begin
          next_pad_oe = 1'b0;
        end
      endcase
    end
  end

  // Two flops on the pad input; the first feeds only the second
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_meta <= 1'b0;
      o_in_level <= 1'b0;
      o_pad_out <= 1'b0;
      o_pad_oe <= 1'b0;
    end else if (i_clk_en) begin
      sync_meta <= i_pad_in;
      o_in_level <= sync_meta;
      o_pad_out <= next_pad_out;
      o_pad_oe <= next_pad_oe;
    end
  end

endmodule

/* core/gvp_regs.sv */
// GPIO pins 5 to 8 and video path control registers with their pad and mode outputs.
// Assumes the forward-channel decoder and video path share the register clock;
// pad inputs are asynchronous and are synchronised in each pin controller.
module gvp_regs
  import gvp_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,

  // Register port
  input wire logic [GVP_ADDR_W-1:0] i_addr,
  input wire logic [GVP_DATA_W-1:0] i_wdata,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [GVP_DATA_W-1:0] o_rdata,

  // Forward-channel settings from the remote serializer
  input wire logic i_fc_load,
  input wire logic [GVP_FC_W-1:0] i_fc_value,

  // Video path
  input wire logic i_video_valid_strobe,
  output logic o_pixel_forward,
  output logic o_content_protect_en,
  output logic o_audio_pkt_out_en,
  output logic o_four_chan_audio,
  output logic o_video_18bit,
  output logic o_audio_inband,

  // Pins 5 to 8, index 0 is pin 5
  input wire logic [GVP_NUM_PINS-1:0] i_func_out,
  input wire logic [GVP_NUM_PINS-1:0] i_remote_level,
  input wire logic [GVP_NUM_PINS-1:0] i_pad_in,
  output logic [GVP_NUM_PINS-1:0] o_pad_out,
  output logic [GVP_NUM_PINS-1:0] o_pad_oe,
  output logic [GVP_NUM_PINS-1:0] o_pad_in_level
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [GVP_DATA_W-1:0] pins_5_6;
  logic [GVP_DATA_W-1:0] pins_7_8;
  gvp_vpath_t video_path;
  logic [GVP_DATA_W-1:0] next_pins_5_6;
  logic [GVP_DATA_W-1:0] next_pins_7_8;
  gvp_vpath_t next_video_path;
  logic [GVP_DATA_W-1:0] next_rdata;

  // Decoded accesses
  logic wr_pins_5_6;
  logic wr_pins_7_8;
  logic wr_video_path;
  logic fc_accept;
  logic [GVP_DATA_W-1:0] read_value;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Writes to unmapped offsets fall through with no effect
  assign wr_pins_5_6 = i_wr_stb && (i_addr == GVP_OFS_PINS_5_6);
  assign wr_pins_7_8 = i_wr_stb && (i_addr == GVP_OFS_PINS_7_8);
  assign wr_video_path = i_wr_stb && (i_addr == GVP_OFS_VIDEO_PATH);

  // Remote reload only while local settings are not held
  assign fc_accept = i_fc_load && !video_path.hold_local_settings;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped offsets read as zero
  always_comb begin
    unique case (i_addr)
      GVP_OFS_PINS_5_6: read_value = pins_5_6;
      GVP_OFS_PINS_7_8: read_value = pins_7_8;
      GVP_OFS_VIDEO_PATH: read_value = video_path;
      default: read_value = '0;
    endcase
  end

  // ----------------------------------------
  // Next register values
  // ----------------------------------------
  // The reserved bit of the pin 7/8 nibble is stored and read back but unused
  always_comb begin
    next_pins_5_6 = pins_5_6;
    next_pins_7_8 = pins_7_8;
    next_video_path = video_path;
    next_rdata = '0;
    if (wr_pins_5_6) begin
      next_pins_5_6 = i_wdata;
    end
    if (wr_pins_7_8) begin
      next_pins_7_8 = i_wdata;
    end
    if (wr_video_path) begin
      next_video_path = i_wdata;
    end
    // Remote value overwrites bits 6..0 last, so it wins a same-cycle write
    if (fc_accept) begin
      next_video_path[GVP_FC_MSB:0] = i_fc_value;
    end
    // Read data stand only in the cycle after the strobe
    if (i_rd_stb) begin
      next_rdata = read_value;
    end
  end

  // Register file flops
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_5_6 <= GVP_RST_PINS_5_6;
      pins_7_8 <= GVP_RST_PINS_7_8;
      video_path <= GVP_RST_VIDEO_PATH;
      o_rdata <= '0;
    end else if (i_clk_en) begin
      pins_5_6 <= next_pins_5_6;
      pins_7_8 <= next_pins_7_8;
      video_path <= next_video_path;
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Video path decode
  // ----------------------------------------
  logic valid_active;
  logic next_pixel_forward;
  logic next_content_protect_en;
  logic next_audio_pkt_out_en;
  logic next_four_chan_audio;
  logic next_video_18bit;
  logic next_audio_inband;

  // Strobe is taken in true sense or inverted per the polarity bit
  assign valid_active = i_video_valid_strobe ^ video_path.video_valid_polarity;

  // Mode outputs from the stored fields
  always_comb begin
    // Unqualified pass ignores the strobe entirely
    next_pixel_forward = video_path.pass_video_unqualified || valid_active;
    // Protection cannot run without framing by the valid strobe
    next_content_protect_en = !video_path.pass_video_unqualified;
    next_audio_pkt_out_en = !video_path.suppress_audio_on_video_pins
                            && !video_path.pass_video_unqualified;
    // Bit 3 low forces four-channel audio off whatever bit 0 holds
    next_four_chan_audio = video_path.four_chan_from_reg
                           && video_path.four_chan_enable;
    next_video_18bit = video_path.video_18bit;
    next_audio_inband = video_path.audio_inband;
  end

  // Registered mode outputs, one cycle behind the register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pixel_forward <= 1'b0;
      o_content_protect_en <= 1'b0;
      o_audio_pkt_out_en <= 1'b0;
      o_four_chan_audio <= 1'b0;
      o_video_18bit <= 1'b0;
      o_audio_inband <= 1'b0;
    end else if (i_clk_en) begin
      o_pixel_forward <= next_pixel_forward;
      o_content_protect_en <= next_content_protect_en;
      o_audio_pkt_out_en <= next_audio_pkt_out_en;
      o_four_chan_audio <= next_four_chan_audio;
      o_video_18bit <= next_video_18bit;
      o_audio_inband <= next_audio_inband;
    end
  end

  // ----------------------------------------
  // Pin configuration
  // ----------------------------------------
  gvp_pin_cfg_t pin_cfg [GVP_NUM_PINS];
  gvp_pin_cfg_t pin7_raw;

  // Pin 7 has no enable bit; its code uses enable 0 (functional or tri-state)
  assign pin7_raw = pins_7_8[GVP_LO_PIN_LSB +: 4];

  always_comb begin
    pin_cfg[0] = pins_5_6[GVP_LO_PIN_LSB +: 4];
    pin_cfg[1] = pins_5_6[GVP_HI_PIN_LSB +: 4];
    pin_cfg[2] = pin7_raw;
    pin_cfg[2].function_enable = 1'b0;
    pin_cfg[3] = pins_7_8[GVP_HI_PIN_LSB +: 4];
  end

  // ----------------------------------------
  // Pin controllers
  // ----------------------------------------
  // Pad drive is registered, so it follows a config write by one cycle
  for (genvar p = 0; p < GVP_NUM_PINS; p++) begin : g_pin
    gvp_pin_ctrl u_pin (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_cfg(pin_cfg[p]),
      .i_func_out(i_func_out[p]),
      .i_remote_level(i_remote_level[p]),
      .i_pad_in(i_pad_in[p]),
      .o_pad_out(o_pad_out[p]),
      .o_pad_oe(o_pad_oe[p]),
      .o_in_level(o_pad_in_level[p])
    );
  end

endmodule

/* test/gvp_chk.sv */
// Bound checker for gvp_regs: pad drive and video path modes after writes.
// Assumes i_clk_en stays high; sees only the gvp_regs ports.
module gvp_chk
  import gvp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Stimulus side
  input wire logic [GVP_ADDR_W-1:0] i_addr,
  input wire logic [GVP_DATA_W-1:0] i_wdata,
  input wire logic i_wr_stb,
  input wire logic i_fc_load,
  input wire logic i_video_valid_strobe,
  input wire logic [GVP_NUM_PINS-1:0] i_func_out,
  input wire logic [GVP_NUM_PINS-1:0] i_remote_level,
  // Watched outputs
  input wire logic o_pixel_forward,
  input wire logic o_content_protect_en,
  input wire logic o_audio_pkt_out_en,
  input wire logic o_four_chan_audio,
  input wire logic o_video_18bit,
  input wire logic o_audio_inband,
  input wire logic [GVP_NUM_PINS-1:0] o_pad_out,
  input wire logic [GVP_NUM_PINS-1:0] o_pad_oe
);
  // Write decodes; a colliding load would win the low bits, so it is excluded
  logic w20;
  logic w22;
  assign w20 = i_wr_stb && i_addr == GVP_OFS_PINS_5_6;
  assign w22 = i_wr_stb && i_addr == GVP_OFS_VIDEO_PATH && !i_fc_load;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Outputs lag the register by one cycle, hence ##2 after the write
  pin_func_a: assert property (
    w20 && i_wdata[2:0] == 3'h0 |-> ##2 o_pad_oe[0] && o_pad_out[0] == $past(i_func_out[0]))
    else $error("pin5 functional drive wrong");
  pin_gp_out_a: assert property (
    w20 && i_wdata[2:0] == 3'h1 |-> ##2 o_pad_oe[0] && o_pad_out[0] == $past(i_wdata[3], 2))
    else $error("pin5 local level wrong");
  pin_off_a: assert property (
    w20 && i_wdata[2:1] == 2'h1 |-> ##2 !o_pad_oe[0])
    else $error("pin5 driven while off");
  pin_remote_a: assert property (
    w20 && i_wdata[6] |-> ##2 o_pad_oe[1] && o_pad_out[1] == $past(i_remote_level[1]))
    else $error("pin6 remote level wrong");
  pass_video_a: assert property (
    w22 && i_wdata[6] |-> ##2 o_pixel_forward && !o_content_protect_en && !o_audio_pkt_out_en)
    else $error("unqualified pass wrong");
  valid_pol_a: assert property (
    w22 && !i_wdata[6]
    |-> ##2 o_pixel_forward == ($past(i_video_valid_strobe) ^ $past(i_wdata[5], 2)))
    else $error("valid polarity wrong");
  audio_pkt_a: assert property (
    w22 |-> ##2 o_audio_pkt_out_en == !($past(i_wdata[4], 2) || $past(i_wdata[6], 2)))
    else $error("audio packet enable wrong");
  four_chan_a: assert property (
    w22 |-> ##2 o_four_chan_audio == ($past(i_wdata[3], 2) && $past(i_wdata[0], 2)))
    else $error("four channel enable wrong");
  width_mode_a: assert property (
    w22 |-> ##2 o_video_18bit == $past(i_wdata[2], 2) && o_audio_inband == $past(i_wdata[1], 2))
    else $error("width or transport wrong");
  hold_load_a: assert property (
    w22 && i_wdata[7] ##1 i_fc_load && !i_wr_stb |-> ##2 o_video_18bit == $past(i_wdata[2], 3))
    else $error("load taken while held");
endmodule

bind gvp_regs gvp_chk i_gvp_chk (.*);

/* test/gvp_ser_model.sv */
// Remote serializer stand-in: forward-channel loads and remote pin levels.
// Assumes the bench requests a load by raising i_go for one cycle.
module gvp_ser_model
  import gvp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Bench request
  input wire logic i_go,
  input wire logic [GVP_FC_W-1:0] i_val,
  // Link side
  output logic o_fc_load,
  output logic [GVP_FC_W-1:0] o_fc_value,
  output logic [GVP_NUM_PINS-1:0] o_remote_level
);
  // Idle value is inverted every cycle so a stale load value never looks valid
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fc_load <= 1'b0;
      o_fc_value <= 7'h00;
      o_remote_level <= 4'h0;
    end else begin
      o_fc_load <= i_go;
      o_fc_value <= i_go ? i_val : ~o_fc_value;
      o_remote_level <= o_remote_level + 4'h1; // Moves every cycle
    end
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for gvp_regs with a serializer model on the link side.
// Assumes the checker bind and the model are compiled before this file.
module tb_top
  import gvp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] wd;
    logic vs;
    logic [5:0] m;
  } gvp_row_t;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr_stb = 1'b0;
  logic i_rd_stb = 1'b0;
  logic i_video_valid_strobe = 1'b0;
  logic [3:0] i_func_out = 4'hb;
  logic [3:0] i_pad_in = 4'h0;
  logic fc_go = 1'b0;
  logic [6:0] fc_val = 7'h00;
  logic i_fc_load;
  logic [6:0] i_fc_value;
  logic [3:0] i_remote_level;
  logic [7:0] o_rdata;
  logic o_pixel_forward, o_content_protect_en, o_audio_pkt_out_en;
  logic o_four_chan_audio, o_video_18bit, o_audio_inband;
  logic [3:0] o_pad_out, o_pad_oe, o_pad_in_level, n, eo, ev, mk;
  logic [7:0] got;
  int n_fail = 0;
  int checked = 0;
  // Mode vector is {pixel, protect, audio pkt, four chan, 18-bit, in-band}
  gvp_row_t rows [6] = '{'{8'h80, 1'b0, 6'h18}, '{8'h49, 1'b0, 6'h24},
    '{8'h11, 1'b1, 6'h30}, '{8'h86, 1'b1, 6'h3b}, '{8'h2c, 1'b0, 6'h3a},
    '{8'h2b, 1'b1, 6'h1d}};
  logic [3:0] nib [6] = '{4'h0, 4'h1, 4'h9, 4'h2, 4'h3, 4'h4};
  logic [7:0] ofs [4] = '{8'h20, 8'h21, 8'h22, 8'h30};

  gvp_regs i_gvp_regs (.*);
  gvp_ser_model i_gvp_ser_model (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_go(fc_go),
    .i_val(fc_val), .o_fc_load(i_fc_load), .o_fc_value(i_fc_value),
    .o_remote_level(i_remote_level));

  always #50 i_ref_clk = ~i_ref_clk;

  // Bus tasks end 1 ns after an edge so a following strobe never collides
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
    #1;
    got = o_rdata;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is about 70 cycles; this cuts a hang at 3000 cycles
  initial begin
    #(3000 * 100);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    cmp({o_pad_oe, o_pad_out}, {4'hf, i_func_out});
    wr(8'h30, 8'hff);
    foreach (ofs[k]) begin
      rd(ofs[k]);
      cmp(got, 8'h00);
    end
    $display("reset and unmapped test done");
    foreach (rows[k]) begin
      i_video_valid_strobe <= rows[k].vs;
      wr(GVP_OFS_VIDEO_PATH, rows[k].wd);
      rd(GVP_OFS_VIDEO_PATH);
      cmp(got, rows[k].wd);
      cmp({2'h0, o_pixel_forward, o_content_protect_en, o_audio_pkt_out_en, o_four_chan_audio,
        o_video_18bit, o_audio_inband}, {2'h0, rows[k].m});
    end
    $display("video path rows done");
    foreach (nib[k]) begin
      n = nib[k];
      wr(GVP_OFS_PINS_5_6, {n, n});
      wr(GVP_OFS_PINS_7_8, {n, n});
      @(posedge i_ref_clk);
      #1;
      eo = (n[2] || !n[1]) ? 4'hb : 4'h0;
      ev = (n[1:0] == 2'h0) ? i_func_out : {4{n[3]}};
      mk = n[2] ? 4'h0 : eo;
      cmp({o_pad_oe & 4'hb, o_pad_out & mk}, {eo, ev & mk});
    end
    i_pad_in <= 4'ha;
    repeat (3) @(posedge i_ref_clk);
    #1;
    cmp({4'h0, o_pad_in_level}, 8'h0a);
    $display("pin test done");
    fc_go <= 1'b1;
    fc_val <= 7'h04;
    @(posedge i_ref_clk);
    fc_go <= 1'b0;
    @(posedge i_ref_clk);
    rd(GVP_OFS_VIDEO_PATH);
    cmp(got, 8'h04);
    cmp({7'h0, o_video_18bit}, 8'h01);
    // Load and local write meet at one edge
    fc_go <= 1'b1;
    @(posedge i_ref_clk);
    fc_go <= 1'b0;
    wr(GVP_OFS_VIDEO_PATH, 8'h81);
    rd(GVP_OFS_VIDEO_PATH);
    cmp(got, 8'h84);
    // Hold set, then a load one cycle later must be ignored
    fc_go <= 1'b1;
    fc_val <= 7'h7f;
    wr(GVP_OFS_VIDEO_PATH, 8'h80);
    fc_go <= 1'b0;
    @(posedge i_ref_clk);
    rd(GVP_OFS_VIDEO_PATH);
    cmp(got, 8'h80);
    $display("forward channel test done");
    conclude();
  end
endmodule
